// file: verilog/fieldbus_pkg.sv
// shared constants and types for the fieldbus word interface
`default_nettype none
package fieldbus_pkg;
   localparam int WORD_W = 32;
   localparam int NARROW_W = 16;
   localparam int IO_WORDS = 24;
   localparam int ADDR_W = 16;
   // largest register index reachable by five-digit numbering (40001..49999)
   localparam logic [15:0] FIVE_DIGIT_LAST = 16'h270E;
   // internal addresses of the cyclic words
   localparam logic [15:0] ADDR_COMMAND = 16'h0000;
   localparam logic [15:0] ADDR_SET_ONE = 16'h0001;
   localparam logic [15:0] ADDR_SET_TWO = 16'h0002;
   localparam logic [15:0] ADDR_STATE = 16'h0003;
   localparam logic [15:0] ADDR_FB_ONE = 16'h0004;
   localparam logic [15:0] ADDR_FB_TWO = 16'h0005;
   localparam logic [15:0] ADDR_IO_BASE = 16'h0010;
   // first address of the wide parameter space
   localparam logic [15:0] ADDR_WIDE_BASE = 16'h2710;
   // command bit positions
   localparam int CB_RAMP_STOP = 0;
   localparam int CB_COAST_STOP = 1;
   localparam int CB_QUICK_STOP = 2;
   localparam int CB_RUN = 3;
   localparam int CB_RAMP_OUT = 4;
   localparam int CB_RAMP_HOLD = 5;
   localparam int CB_RAMP_IN = 6;
   localparam int CB_FAULT_CLEAR = 7;
   localparam int CB_REMOTE = 10;
   localparam int CB_LOCATION = 11;
   localparam logic [15:0] CMD_USED_MASK = 16'h0CFF;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      converting_classic_profile = 2'b00,
      converting_enhanced_profile = 2'b01,
      transparent_narrow_profile = 2'b10,
      transparent_wide_profile = 2'b11
   } profile_e;

   typedef enum logic [2:0] {
      st_inhibited = 3'b000,
      st_ready_on = 3'b001,
      st_ready_run = 3'b010,
      st_enabled = 3'b011,
      st_ramp_stop = 3'b100,
      st_coast_stop = 3'b101,
      st_quick_stop = 3'b110,
      st_fault = 3'b111
   } drive_state_e;

   typedef enum logic [1:0] {
      req_idle = 2'b00,
      req_write = 2'b01,
      req_read = 2'b10
   } req_e;

   // narrow words: sign bit plus 15-bit magnitude, sign extended
   function automatic logic [31:0] widen(input logic [15:0] w);
      widen = {{16{w[15]}}, w};
   endfunction : widen

   // saturate a wide signed value into the narrow signed range
   function automatic logic [15:0] narrow(input logic [31:0] w);
      if (!w[31] && w[30:15] != 16'h0000) begin
         narrow = 16'h7FFF;
      end else if (w[31] && w[30:15] != 16'hFFFF) begin
         narrow = 16'h8000;
      end else begin
         narrow = w[15:0];
      end
   endfunction : narrow
endpackage : fieldbus_pkg
`default_nettype wire

// file: verilog/fieldbus_link_if.sv
// register request link between fieldbus master and drive
`default_nettype none
interface fieldbus_link_if;
   import fieldbus_pkg::*;
   logic req_valid;
   logic req_write_n;
   logic [15:0] req_addr;
   logic [31:0] req_data;
   logic rsp_valid;
   logic rsp_error;
   logic [31:0] rsp_data;
   modport master (output req_valid, output req_write_n, output req_addr,
                   output req_data, input rsp_valid, input rsp_error,
                   input rsp_data);
   modport drive (input req_valid, input req_write_n, input req_addr,
                  input req_data, output rsp_valid, output rsp_error,
                  output rsp_data);
endinterface : fieldbus_link_if
`default_nettype wire

// file: verilog/command_decoder.sv
// decodes the command word into drive state and ramp controls
`default_nettype none
module command_decoder
   import fieldbus_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] command_word,
   input wire logic fault_in,
   input wire logic run_from_bus,
   input wire logic ramp_in_from_bus,
   input wire logic clear_from_bus,
   input wire logic location_from_bus,
   input wire logic run_enable_ext,
   output logic [2:0] drive_state,
   output logic ramp_out_zero,
   output logic ramp_hold,
   output logic ramp_in_zero,
   output logic location_select,
   output logic fault_cleared
);
   typedef struct packed {
      drive_state_e state;
      logic clear_prev;
      logic out_zero;
      logic hold;
      logic in_zero;
      logic loc;
      logic cleared;
   } dec_s;

   dec_s r;
   dec_s next_r;
   logic run_ok;

   always_comb begin
      next_r = r;
      next_r.cleared = 1'b0;
      run_ok = run_from_bus ? command_word[CB_RUN] : run_enable_ext; // [RQ14]
      next_r.clear_prev = command_word[CB_FAULT_CLEAR];
      case (r.state)
         st_fault: begin
            if (clear_from_bus && command_word[CB_FAULT_CLEAR] &&
                !r.clear_prev) begin
               next_r.state = st_inhibited; // [RQ18]
               next_r.cleared = 1'b1;
            end
         end
         st_coast_stop, st_quick_stop: begin
            next_r.state = st_inhibited; // [RQ12] [RQ13]
         end
         st_ramp_stop: begin
            next_r.state = st_ready_on; // [RQ11]
         end
         default: begin
            if (!command_word[CB_COAST_STOP]) begin
               // inhibited drive stays put, no stop-state ping-pong
               if (r.state != st_inhibited) begin
                  next_r.state = st_coast_stop; // [RQ12]
               end
            end else if (!command_word[CB_QUICK_STOP]) begin
               if (r.state != st_inhibited) begin
                  next_r.state = st_quick_stop; // [RQ13]
               end
            end else if (!command_word[CB_RAMP_STOP]) begin
               if (r.state == st_inhibited) begin
                  next_r.state = st_ready_on; // [RQ11]
               end else if (r.state != st_ready_on) begin
                  next_r.state = st_ramp_stop; // [RQ11]
               end
            end else if (r.state == st_inhibited) begin
               next_r.state = st_ready_on;
            end else if (r.state == st_ready_on) begin
               next_r.state = st_ready_run; // [RQ11]
            end else if (command_word[CB_RUN] && run_ok) begin
               next_r.state = st_enabled; // [RQ14]
            end else begin
               next_r.state = st_ready_run; // [RQ14]
            end
         end
      endcase
      if (fault_in) begin
         next_r.state = st_fault;
      end
      next_r.out_zero = !command_word[CB_RAMP_OUT]; // [RQ15]
      next_r.hold = !command_word[CB_RAMP_HOLD]; // [RQ16]
      if (ramp_in_from_bus) begin
         next_r.in_zero = !command_word[CB_RAMP_IN]; // [RQ17]
      end else begin
         next_r.in_zero = 1'b0;
      end
      if (location_from_bus) begin
         next_r.loc = command_word[CB_LOCATION]; // [RQ20]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: st_inhibited, clear_prev: 1'b0, out_zero: 1'b1,
                hold: 1'b1, in_zero: 1'b1, loc: 1'b0, cleared: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign drive_state = r.state;
   assign ramp_out_zero = r.out_zero;
   assign ramp_hold = r.hold;
   assign ramp_in_zero = r.in_zero;
   assign location_select = r.loc;
   assign fault_cleared = r.cleared;
endmodule : command_decoder
`default_nettype wire

// file: verilog/drive_end.sv
// drive side of the embedded bus port: word map, profiles, commands
//
// How it works
// (RQ1) words 16 bits, wide transparent uses 32
// (RQ2) command word stored, drives state changes; transparent profiles feed the decoder a fixed 0x0006 instead
// (RQ3) state report word returned, maybe converted
// (RQ4) setpoints stored, passed or scaled
// (RQ5) feedback words returned, passed or scaled
// (RQ6) 24 data words bound to configured addresses
// (RQ7) 16-bit register address field
// (RQ8) five-digit masters reach first 9999 only
// (RQ9) no wide register in five-digit range
// (RQ10) four profiles, two convert, two transparent
// (RQ11) bit 0 ramp stop sequence
// (RQ12) bit 1 low coasts to stop
// (RQ13) bit 2 low quick stop
// (RQ14) bit 3 enables operation with run permission
// (RQ15) bit 4 low zeroes ramp output
// (RQ16) bit 5 low holds ramp output
// (RQ17) bit 6 low zeroes ramp input
// (RQ18) bit 7 rising edge clears fault
// (RQ19) bit 10 remote control, hold last word
// (RQ20) bit 11 selects external location
// (RQ21) narrow setpoint is sign plus 15 bits
// (RQ22) reserved command bits ignored
`default_nettype none
module drive_end
   import fieldbus_pkg::*;
#(
   parameter int IO_COUNT = IO_WORDS
)(
   input wire logic mclk,
   input wire logic rst_n,
   fieldbus_link_if.drive link,
   input wire logic [1:0] profile_sel,
   input wire logic [IO_COUNT*16-1:0] io_addr_cfg,
   input wire logic [IO_COUNT-1:0] io_is_output,
   input wire logic [31:0] internal_state_word,
   input wire logic [31:0] feedback_one,
   input wire logic [31:0] feedback_two,
   input wire logic [IO_COUNT*32-1:0] io_input_values,
   input wire logic fault_in,
   input wire logic run_from_bus,
   input wire logic ramp_in_from_bus,
   input wire logic clear_from_bus,
   input wire logic location_from_bus,
   input wire logic run_enable_ext,
   output logic [31:0] command_word,
   output logic [31:0] setpoint_one,
   output logic [31:0] setpoint_two,
   output logic [IO_COUNT*32-1:0] io_output_values,
   output logic bus_control,
   output logic [2:0] drive_state,
   output logic ramp_out_zero,
   output logic ramp_hold,
   output logic ramp_in_zero,
   output logic location_select,
   output logic fault_cleared
);
   typedef struct packed {
      logic [31:0] cmd;
      logic [31:0] sp1;
      logic [31:0] sp2;
      logic [IO_COUNT*32-1:0] io_out;
      logic remote;
      logic rsp_valid;
      logic rsp_error;
      logic [31:0] rsp_data;
   } drv_s;

   drv_s r;
   drv_s next_r;
   profile_e prof;
   logic converting;
   logic wide;
   logic [31:0] wdata;
   logic [31:0] cmd_eff;
   logic hit;
   logic [15:0] dec_cmd;

   // ----------------------------------------
   // word conversion
   // ----------------------------------------
   function automatic logic [31:0] to_drive(input logic [31:0] w,
                                            input logic is_wide);
      to_drive = is_wide ? w : widen(w[15:0]); // [RQ1] [RQ21] [RQ4]
   endfunction : to_drive

   function automatic logic [31:0] to_bus(input logic [31:0] w,
                                          input logic is_wide);
      to_bus = is_wide ? w : {16'h0000, narrow(w)}; // [RQ5]
   endfunction : to_bus

   // ----------------------------------------
   // request handling
   // ----------------------------------------
   always_comb begin
      next_r = r;
      prof = profile_e'(profile_sel); // [RQ10]
      converting = (prof == converting_classic_profile) ||
                   (prof == converting_enhanced_profile);
      wide = (prof == transparent_wide_profile);
      wdata = wide ? link.req_data : {16'h0000, link.req_data[15:0]};
      cmd_eff = 32'h0000_0000;
      hit = 1'b0;
      next_r.rsp_valid = 1'b0;
      next_r.rsp_error = 1'b0;
      next_r.rsp_data = 32'h0000_0000;
      if (link.req_valid) begin
         next_r.rsp_valid = 1'b1;
         // wide words sit above the five-digit range only
         if (wide && link.req_addr < ADDR_WIDE_BASE) begin
            next_r.rsp_error = 1'b1; // [RQ9]
         end else if (!link.req_write_n) begin
            case (link.req_addr) // [RQ7]
               ADDR_COMMAND, ADDR_COMMAND + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  cmd_eff = converting ?
                     (wdata & {16'h0000, CMD_USED_MASK}) : wdata; // [RQ22]
                  if (!converting || cmd_eff[CB_REMOTE]) begin
                     next_r.cmd = cmd_eff; // [RQ2]
                     next_r.remote = 1'b1; // [RQ19]
                  end else if (cmd_eff == 32'h0 && r.sp1 == 32'h0) begin
                     // all-zero word takes control while setpoint one is zero
                     next_r.remote = 1'b1; // [RQ19]
                  end
               end
               ADDR_SET_ONE, ADDR_SET_ONE + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  if (!converting || r.remote) begin
                     next_r.sp1 = to_drive(wdata, wide); // [RQ4]
                  end
               end
               ADDR_SET_TWO, ADDR_SET_TWO + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  if (!converting || r.remote) begin
                     next_r.sp2 = to_drive(wdata, wide); // [RQ4]
                  end
               end
               default: begin
                  hit = 1'b0;
               end
            endcase
            for (int i = 0; i < IO_COUNT; i++) begin
               if (io_is_output[i] &&
                   link.req_addr == io_addr_cfg[i*16 +: 16]) begin
                  hit = 1'b1;
                  next_r.io_out[i*32 +: 32] = wdata; // [RQ6]
               end
            end
            next_r.rsp_error = !hit;
         end else begin
            case (link.req_addr)
               ADDR_COMMAND, ADDR_COMMAND + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  next_r.rsp_data = r.cmd;
               end
               ADDR_STATE, ADDR_STATE + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  next_r.rsp_data = wide ? internal_state_word :
                     {16'h0000, internal_state_word[15:0]}; // [RQ3]
               end
               ADDR_FB_ONE, ADDR_FB_ONE + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  next_r.rsp_data = to_bus(feedback_one, wide); // [RQ5]
               end
               ADDR_FB_TWO, ADDR_FB_TWO + ADDR_WIDE_BASE: begin
                  hit = 1'b1;
                  next_r.rsp_data = to_bus(feedback_two, wide); // [RQ5]
               end
               default: begin
                  hit = 1'b0;
               end
            endcase
            for (int i = 0; i < IO_COUNT; i++) begin
               if (!io_is_output[i] &&
                   link.req_addr == io_addr_cfg[i*16 +: 16]) begin
                  hit = 1'b1;
                  next_r.rsp_data = wide ? io_input_values[i*32 +: 32] :
                     {16'h0000, io_input_values[i*32 +: 16]}; // [RQ6]
               end
            end
            next_r.rsp_error = !hit;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // transparent profiles carry no decoded commands
   assign dec_cmd = converting ? r.cmd[15:0] : 16'h0006;

   command_decoder decoder (
      .mclk(mclk),
      .rst_n(rst_n),
      .command_word(dec_cmd),
      .fault_in(fault_in),
      .run_from_bus(run_from_bus),
      .ramp_in_from_bus(ramp_in_from_bus),
      .clear_from_bus(clear_from_bus),
      .location_from_bus(location_from_bus),
      .run_enable_ext(run_enable_ext),
      .drive_state(drive_state),
      .ramp_out_zero(ramp_out_zero),
      .ramp_hold(ramp_hold),
      .ramp_in_zero(ramp_in_zero),
      .location_select(location_select),
      .fault_cleared(fault_cleared)
   );

   assign link.rsp_valid = r.rsp_valid;
   assign link.rsp_error = r.rsp_error;
   assign link.rsp_data = r.rsp_data;
   assign command_word = r.cmd;
   assign setpoint_one = r.sp1;
   assign setpoint_two = r.sp2;
   assign io_output_values = r.io_out;
   assign bus_control = r.remote;
endmodule : drive_end
`default_nettype wire

// file: verilog/master_end.sv
// fieldbus master side: issues one register request at a time
`default_nettype none
module master_end
   import fieldbus_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   fieldbus_link_if.master link,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [15:0] cmd_addr,
   input wire logic [31:0] cmd_data,
   input wire logic wide_mode,
   output logic cmd_ready,
   output logic done,
   output logic done_error,
   output logic [31:0] done_data
);
   typedef struct packed {
      req_e state;
      logic valid;
      logic write_n;
      logic [15:0] addr;
      logic [31:0] data;
      logic done;
      logic err;
      logic [31:0] rdata;
      logic ready;
   } mst_s;

   mst_s r;
   mst_s next_r;

   always_comb begin
      next_r = r;
      next_r.valid = 1'b0;
      next_r.done = 1'b0;
      case (r.state)
         req_idle: begin
            if (cmd_valid) begin
               next_r.valid = 1'b1;
               next_r.write_n = !cmd_write; // [RQ2]
               next_r.addr = cmd_addr; // [RQ7] [RQ8]
               // narrow profiles carry 16-bit words only
               next_r.data = wide_mode ? cmd_data :
                  {16'h0000, cmd_data[15:0]}; // [RQ1] [RQ21]
               next_r.state = cmd_write ? req_write : req_read;
            end
         end
         req_write, req_read: begin
            if (link.rsp_valid) begin
               next_r.done = 1'b1;
               next_r.err = link.rsp_error;
               next_r.rdata = link.rsp_data;
               next_r.state = req_idle;
            end
         end
         default: begin
            next_r.state = req_idle;
         end
      endcase
      next_r.ready = (next_r.state == req_idle);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: req_idle, valid: 1'b0, write_n: 1'b0, addr: 16'h0000,
                data: 32'h0000_0000, done: 1'b0, err: 1'b0,
                rdata: 32'h0000_0000, ready: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign link.req_valid = r.valid;
   assign link.req_write_n = r.write_n;
   assign link.req_addr = r.addr;
   assign link.req_data = r.data;
   assign cmd_ready = r.ready;
   assign done = r.done;
   assign done_error = r.err;
   assign done_data = r.rdata;
endmodule : master_end
`default_nettype wire

// file: verification/fieldbus_link_monitor.sv
// interface checker for the fieldbus request link
`default_nettype none
module fieldbus_link_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_write_n,
   input wire logic [15:0] req_addr,
   input wire logic [31:0] req_data,
   input wire logic rsp_valid,
   input wire logic rsp_error,
   input wire logic [31:0] rsp_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // handshake
   // ----------------------------------------------------------------
   AST_REQ_PULSE: assert property (req_valid |=> !req_valid)
      else $error("request held longer than one cycle");
   AST_RSP_NEXT: assert property (req_valid |=> rsp_valid)
      else $error("no answer one cycle after request");
   AST_RSP_CAUSE: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without a request");
   AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer held longer than one cycle");
   AST_ERR_WITH_RSP: assert property (rsp_error |-> rsp_valid)
      else $error("error flag outside an answer");
   AST_DATA_IDLE: assert property (!rsp_valid |-> rsp_data == 32'h0)
      else $error("read data not zero between answers");
   AST_ONE_OUT: assert property (rsp_valid |-> !req_valid)
      else $error("second request while one outstanding");
   // ----------------------------------------------------------------
   // address map; bench keeps data words at 0x0010 upward
   // ----------------------------------------------------------------
   AST_GAP_UNMAPPED: assert property (
      req_valid && req_addr inside {[16'h0006:16'h000F]} |=> rsp_error)
      else $error("gap address answered without error");
   AST_TOP_UNMAPPED: assert property (
      req_valid && req_addr >= 16'h2716 |=> rsp_error)
      else $error("high address answered without error");
   cover property (req_valid && !req_write_n ##1 rsp_valid && !rsp_error);
   cover property (req_valid && req_write_n ##1 rsp_valid && !rsp_error);
   cover property (rsp_valid && rsp_error);
endmodule : fieldbus_link_monitor
`default_nettype wire

// file: verification/tb.sv
// self-checking bench: master end and drive end across the link
`default_nettype none
module tb
   import fieldbus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, wide_mode = 1'b0;
   logic [15:0] cmd_addr = 16'h0;
   logic [31:0] cmd_data = 32'h0;
   logic cmd_ready, done, done_error;
   logic [31:0] done_data;
   logic [1:0] profile_sel = 2'b00;
   logic [IO_WORDS*16-1:0] io_addr_cfg;
   logic [IO_WORDS-1:0] io_is_output = 24'h000001;
   logic [31:0] state_in = 32'hA5A5_1234, fb_one = 32'h123, fb_two = 32'h10000;
   logic [IO_WORDS*32-1:0] io_in;
   logic fault_in = 1'b0, seen_clear = 1'b0;
   logic [31:0] command_word, setpoint_one, setpoint_two;
   logic [IO_WORDS*32-1:0] io_out;
   logic bus_control, ramp_out_zero, ramp_hold, ramp_in_zero;
   logic location_select, fault_cleared;
   logic [2:0] drive_state;
   int fail_count = 0;
   int n_tests = 0;
   logic [15:0] steps [11] = '{16'h0476, 16'h0477, 16'h047F, 16'h047D,
      16'h0476, 16'h0477, 16'h047F, 16'h047B, 16'h0477, 16'h047F, 16'h047E};
   logic [2:0] goals [11] = '{3'd1, 3'd2, 3'd3, 3'd0, 3'd1, 3'd2, 3'd3,
      3'd0, 3'd2, 3'd3, 3'd1};

   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (fault_cleared === 1'b1) seen_clear <= 1'b1;

   fieldbus_link_if link ();
   master_end master_end_i (.mclk(mclk), .rst_n(rst_n), .link(link),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .wide_mode(wide_mode), .cmd_ready(cmd_ready),
      .done(done), .done_error(done_error), .done_data(done_data));
   drive_end drive_end_i (.mclk(mclk), .rst_n(rst_n), .link(link),
      .profile_sel(profile_sel), .io_addr_cfg(io_addr_cfg),
      .io_is_output(io_is_output), .internal_state_word(state_in),
      .feedback_one(fb_one), .feedback_two(fb_two),
      .io_input_values(io_in), .fault_in(fault_in), .run_from_bus(1'b1),
      .ramp_in_from_bus(1'b1), .clear_from_bus(1'b1),
      .location_from_bus(1'b1), .run_enable_ext(1'b1),
      .command_word(command_word), .setpoint_one(setpoint_one),
      .setpoint_two(setpoint_two), .io_output_values(io_out),
      .bus_control(bus_control), .drive_state(drive_state),
      .ramp_out_zero(ramp_out_zero), .ramp_hold(ramp_hold),
      .ramp_in_zero(ramp_in_zero), .location_select(location_select),
      .fault_cleared(fault_cleared));
   fieldbus_link_monitor fieldbus_link_monitor_i (.mclk(mclk),
      .rst_n(rst_n), .req_valid(link.req_valid),
      .req_write_n(link.req_write_n), .req_addr(link.req_addr),
      .req_data(link.req_data), .rsp_valid(link.rsp_valid),
      .rsp_error(link.rsp_error), .rsp_data(link.rsp_data));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic e,
                      input logic [31:0] x);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 20);
      chk({31'h0, done}, 32'h1);
      chk({31'h0, done_error}, {31'h0, e});
      if (!w && !e) chk(done_data, x);
   endtask : acc

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask : settle

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      for (int k = 0; k < IO_WORDS; k++) begin
         io_addr_cfg[k*16 +: 16] = ADDR_IO_BASE + 16'(k);
         io_in[k*32 +: 32] = 32'h1000 + 32'(k);
      end
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk(command_word, 32'h0);
      chk({29'h0, drive_state}, 32'h0);
      acc(1'b0, 16'h0008, 32'h0, 1'b1, 32'h0);
      acc(1'b0, 16'hFFFF, 32'h0, 1'b1, 32'h0);
      acc(1'b0, ADDR_FB_ONE, 32'h0, 1'b0, 32'h123);
      acc(1'b0, ADDR_FB_TWO, 32'h0, 1'b0, 32'h7FFF);
      acc(1'b1, ADDR_SET_ONE, 32'h100, 1'b0, 32'h0);
      chk(setpoint_one, 32'h0);
      chk({31'h0, bus_control}, 32'h0);
      // all-zero command word takes control without storing anything
      acc(1'b1, ADDR_COMMAND, 32'h0, 1'b0, 32'h0);
      chk({31'h0, bus_control}, 32'h1);
      // state walk: stop modes each reached from operation enabled
      for (int i = 0; i < 11; i++) begin
         acc(1'b1, ADDR_COMMAND, {16'h0, steps[i]}, 1'b0, 32'h0);
         settle();
         chk(32'(drive_state), 32'(goals[i]));
      end
      chk({31'h0, bus_control}, 32'h1);
      acc(1'b1, ADDR_COMMAND, 32'hFF7F, 1'b0, 32'h0);
      settle();
      chk(command_word, 32'h0C7F);
      chk({31'h0, location_select}, 32'h1);
      chk({31'h0, ramp_out_zero}, 32'h0);
      chk({31'h0, ramp_hold}, 32'h0);
      chk({31'h0, ramp_in_zero}, 32'h0);
      acc(1'b1, ADDR_COMMAND, 32'h040F, 1'b0, 32'h0);
      settle();
      chk({31'h0, ramp_out_zero}, 32'h1);
      chk({31'h0, ramp_hold}, 32'h1);
      chk({31'h0, ramp_in_zero}, 32'h1);
      chk({31'h0, location_select}, 32'h0);
      acc(1'b1, ADDR_COMMAND, 32'h000F, 1'b0, 32'h0);
      chk(command_word, 32'h040F);
      @(posedge mclk);
      fault_in <= 1'b1;
      settle();
      chk({29'h0, drive_state}, 32'h7);
      @(posedge mclk);
      fault_in <= 1'b0;
      acc(1'b1, ADDR_COMMAND, 32'h0406, 1'b0, 32'h0);
      settle();
      chk({29'h0, drive_state}, 32'h7);
      acc(1'b1, ADDR_COMMAND, 32'h0486, 1'b0, 32'h0);
      settle();
      chk({31'h0, seen_clear}, 32'h1);
      chk({31'h0, drive_state == 3'd7}, 32'h0);
      acc(1'b0, ADDR_COMMAND, 32'h0, 1'b0, 32'h0486);
      acc(1'b1, ADDR_SET_ONE, 32'h8001, 1'b0, 32'h0);
      chk(setpoint_one, 32'hFFFF_8001);
      acc(1'b1, ADDR_SET_TWO, 32'hFFFF, 1'b0, 32'h0);
      chk(setpoint_two, 32'hFFFF_FFFF);
      // narrow transparent: no masking, data words mapped
      @(posedge mclk);
      profile_sel <= 2'b10;
      acc(1'b1, ADDR_COMMAND, 32'hFF00, 1'b0, 32'h0);
      chk(command_word, 32'h0000_FF00);
      acc(1'b1, 16'h0010, 32'h55AA, 1'b0, 32'h0);
      chk(io_out[31:0], 32'h55AA);
      acc(1'b0, 16'h0011, 32'h0, 1'b0, 32'h1001);
      acc(1'b0, ADDR_STATE, 32'h0, 1'b0, 32'h1234);
      // wide transparent: only the upper alias is reachable
      @(posedge mclk);
      profile_sel <= 2'b11;
      wide_mode <= 1'b1;
      acc(1'b0, ADDR_FB_ONE, 32'h0, 1'b1, 32'h0);
      acc(1'b0, 16'h2715, 32'h0, 1'b0, 32'h10000);
      acc(1'b0, 16'h2713, 32'h0, 1'b0, 32'hA5A5_1234);
      acc(1'b1, 16'h2711, 32'h1234_5678, 1'b0, 32'h0);
      chk(setpoint_one, 32'h1234_5678);
      results();
   end

   initial begin
      #(25ns * 5000);
      fail_count++;
      results();
   end
endmodule : tb
`default_nettype wire
